// file: src/ppc_pkg.sv
// Register map, field layouts and timing constants of the parallel port
package ppc_pkg;
   localparam logic [7:0] OFS_PORT_ENABLE = 8'h00;
   localparam logic [7:0] OFS_CTRL_LOW = 8'h04;
   localparam logic [7:0] OFS_MODE_HIGH = 8'h08;
   localparam logic [7:0] OFS_WAIT_CFG = 8'h0C;
   localparam logic [7:0] OFS_PIN_EN_HIGH = 8'h10;
   localparam logic [7:0] OFS_PIN_EN_LOW = 8'h14;
   localparam logic [7:0] OFS_IN_STATUS = 8'h18;
   localparam logic [7:0] OFS_ADDRESS = 8'h1C;
   localparam logic [7:0] OFS_DATA = 8'h20;
   localparam logic [7:0] OFS_IN_BUF0 = 8'h24;
   localparam logic [7:0] OFS_IN_BUF3 = 8'h30;

   localparam int BIT_PORT_ENABLE = 7;
   localparam int BIT_BUSY = 7;
   localparam int BIT_ALL_FULL = 7;
   localparam int BIT_OVERFLOW = 6;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;

   // One clock is one instruction cycle
   localparam int TCY_NS = 50;
   localparam int CLK_NS = 50;
   localparam int CYC_PER_TCY = (TCY_NS + CLK_NS - 1) / CLK_NS;

   localparam logic [1:0] CSF_ADDR = 2'b00;
   localparam logic [1:0] CSF_ONE_SEL = 2'b01;
   localparam logic [1:0] CSF_TWO_SEL = 2'b10;
   localparam logic [1:0] MODE_LEGACY = 2'b00;
   localparam logic [1:0] MODE_ENHANCED = 2'b01;
   localparam logic [1:0] MODE_MASTER2 = 2'b10;
   localparam logic [1:0] MODE_MASTER1 = 2'b11;
   localparam logic [1:0] IRQ_NONE = 2'b00;
   localparam logic [1:0] IRQ_EACH = 2'b01;
   localparam logic [1:0] IRQ_STALL = 2'b10;
   localparam logic [1:0] IRQ_BUF3 = 2'b11;
   localparam logic [1:0] STEP_NONE = 2'b00;
   localparam logic [1:0] STEP_INC = 2'b01;
   localparam logic [1:0] STEP_DEC = 2'b10;
   localparam logic [1:0] STEP_BUFS = 2'b11;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [1:0] csf;
      logic addr_latch_polarity;
      logic second_select_polarity;
      logic first_select_polarity;
      logic byte_lane_polarity;
      logic write_strobe_polarity;
      logic read_strobe_polarity;
   } ppc_ctrl_t;

   typedef struct packed {
      logic busy;
      logic [1:0] irqm;
      logic [1:0] step;
      logic wide;
      logic [1:0] mode;
   } ppc_mode_t;

   typedef struct packed {
      logic [1:0] setup;
      logic [3:0] strobe;
      logic [1:0] hold;
   } ppc_wait_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_STROBE = 4'b0100,
      ST_HOLD = 4'b1000
   } ppc_state_t;
endpackage : ppc_pkg

// file: src/ppc_port_top.sv
// Parallel port configuration, status, master timing and slave input buffers
module ppc_port_top #(
   parameter int ADDR_W = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   output logic [1:0] o_s_axi_bresp,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   input wire logic [ADDR_W-1:0] i_s_axi_araddr,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   input wire logic i_select_one,
   input wire logic i_write_strobe_pin,
   input wire logic i_read_strobe_pin,
   input wire logic [1:0] i_addr_pins,
   input wire logic [7:0] i_data_pins,
   output logic [15:0] o_addr_pins,
   output logic [15:0] o_addr_oe,
   output logic o_addr_latch_low,
   output logic o_addr_latch_high,
   output logic o_byte_enable_pin,
   output logic o_write_strobe_pin,
   output logic o_read_strobe_pin,
   output logic o_enable_strobe_pin,
   output logic o_strobe_oe,
   output logic [7:0] o_data_pins,
   output logic o_data_oe,
   output logic o_cycle_irq,
   output logic o_cpu_stall
);
   logic en_r;
   ppc_pkg::ppc_ctrl_t ctl_r;
   ppc_pkg::ppc_mode_t mode_r;
   ppc_pkg::ppc_wait_t wait_r;
   logic [15:0] pen_r;
   logic ovf_r;
   logic [3:0] full_r;
   logic [1:0] ptr_r;
   logic [15:0] addr_r;
   logic [15:0] data_r;
   logic [7:0] ibuf [0:3];
   ppc_pkg::ppc_state_t state_r;
   logic [3:0] cnt_r;
   logic second_r;
   logic dir_rd_r;
   logic busy_r;
   logic aw_hold_r;
   logic w_hold_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;

   logic master;
   logic wr_go;
   logic rd_go;
   logic [7:0] wa;
   logic [7:0] ra;
   logic start;
   logic byte_end;
   logic done;
   logic all_full;
   logic [31:0] rd_word;
   logic rd_err;

   assign master = mode_r.mode[1];
   assign wa = 8'(aw_addr_r);
   assign ra = 8'(i_s_axi_araddr);
   assign wr_go = aw_hold_r && w_hold_r && !o_s_axi_bvalid;
   assign rd_go = i_s_axi_arvalid && o_s_axi_arready;
   // Accesses to the data register while busy or disabled are dropped
   assign start = en_r && master && state_r == ppc_pkg::ST_IDLE
      && ((wr_go && wa == ppc_pkg::OFS_DATA)
      || (rd_go && ra == ppc_pkg::OFS_DATA));
   assign byte_end = (state_r == ppc_pkg::ST_STROBE && cnt_r == 4'h0
      && wait_r.strobe == 4'h0)
      || (state_r == ppc_pkg::ST_HOLD && cnt_r == 4'h0);
   assign done = byte_end && (!mode_r.wide || second_r);

   // AXI4-Lite channel handshakes
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_s_axi_awready <= 1'b1;
         o_s_axi_wready <= 1'b1;
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= ppc_pkg::RESP_OKAY;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= i_s_axi_awaddr;
            o_s_axi_awready <= 1'b0;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= i_s_axi_wdata;
            w_strb_r <= i_s_axi_wstrb;
            o_s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= (wa > ppc_pkg::OFS_IN_BUF3 || wa[1:0] != 2'b00)
               ? ppc_pkg::RESP_SLVERR : ppc_pkg::RESP_OKAY;
         end
         if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_err = 1'b0;
      case (ra)
         ppc_pkg::OFS_PORT_ENABLE: rd_word[ppc_pkg::BIT_PORT_ENABLE] = en_r;
         ppc_pkg::OFS_CTRL_LOW: rd_word[7:0] = ctl_r;
         ppc_pkg::OFS_MODE_HIGH: rd_word[7:0] = {busy_r, mode_r[6:0]};
         ppc_pkg::OFS_WAIT_CFG: rd_word[7:0] = wait_r;
         ppc_pkg::OFS_PIN_EN_HIGH: rd_word[7:0] = pen_r[15:8];
         ppc_pkg::OFS_PIN_EN_LOW: rd_word[7:0] = pen_r[7:0];
         ppc_pkg::OFS_IN_STATUS: rd_word[7:0] = {all_full, ovf_r, 2'b00, full_r};
         ppc_pkg::OFS_ADDRESS: rd_word[15:0] = addr_r;
         ppc_pkg::OFS_DATA: rd_word[15:0] = data_r;
         default: begin
            if (ra >= ppc_pkg::OFS_IN_BUF0 && ra <= ppc_pkg::OFS_IN_BUF3
               && ra[1:0] == 2'b00) begin
               rd_word[7:0] = ibuf[2'(ra - ppc_pkg::OFS_IN_BUF0 >> 2)];
            end else begin
               rd_err = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h0000_0000;
         o_s_axi_rresp <= ppc_pkg::RESP_OKAY;
      end else if (rd_go) begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= rd_word;
         o_s_axi_rresp <= rd_err ? ppc_pkg::RESP_SLVERR : ppc_pkg::RESP_OKAY;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_arready <= 1'b1;
      end
   end

   // Configuration registers
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         en_r <= 1'b0;
         ctl_r <= ppc_pkg::RESET_BYTE;
         mode_r <= ppc_pkg::RESET_BYTE;
         wait_r <= ppc_pkg::RESET_BYTE;
         pen_r <= ppc_pkg::RESET_WORD;
      end else if (wr_go && w_strb_r[0]) begin
         case (wa)
            ppc_pkg::OFS_PORT_ENABLE:
               en_r <= w_data_r[ppc_pkg::BIT_PORT_ENABLE];
            ppc_pkg::OFS_CTRL_LOW: ctl_r <= w_data_r[7:0];
            ppc_pkg::OFS_MODE_HIGH: mode_r <= {1'b0, w_data_r[6:0]};
            ppc_pkg::OFS_WAIT_CFG: wait_r <= w_data_r[7:0];
            ppc_pkg::OFS_PIN_EN_HIGH: pen_r[15:8] <= w_data_r[7:0];
            ppc_pkg::OFS_PIN_EN_LOW: pen_r[7:0] <= w_data_r[7:0];
            default: ;
         endcase
      end
   end

   // Master transfer sequencer
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= ppc_pkg::ST_IDLE;
         cnt_r <= 4'h0;
         second_r <= 1'b0;
         dir_rd_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         case (state_r)
            ppc_pkg::ST_IDLE: begin
               if (start) begin
                  busy_r <= 1'b1;
                  second_r <= 1'b0;
                  dir_rd_r <= rd_go && ra == ppc_pkg::OFS_DATA;
                  if (wait_r.strobe == 4'h0) begin
                     state_r <= ppc_pkg::ST_STROBE;
                     cnt_r <= 4'h0;
                  end else begin
                     state_r <= ppc_pkg::ST_SETUP;
                     cnt_r <= {2'b00, wait_r.setup};
                  end
               end
            end
            ppc_pkg::ST_SETUP: begin
               if (cnt_r == 4'h0) begin
                  state_r <= ppc_pkg::ST_STROBE;
                  cnt_r <= wait_r.strobe;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            ppc_pkg::ST_STROBE, ppc_pkg::ST_HOLD: begin
               if (cnt_r != 4'h0) begin
                  cnt_r <= cnt_r - 4'h1;
               end else if (state_r == ppc_pkg::ST_STROBE
                  && wait_r.strobe != 4'h0) begin
                  state_r <= ppc_pkg::ST_HOLD;
                  cnt_r <= {2'b00, wait_r.hold};
               end else if (done || !en_r) begin
                  state_r <= ppc_pkg::ST_IDLE;
                  busy_r <= 1'b0;
               end else begin
                  second_r <= 1'b1;
                  if (wait_r.strobe == 4'h0) begin
                     state_r <= ppc_pkg::ST_STROBE;
                  end else begin
                     state_r <= ppc_pkg::ST_SETUP;
                     cnt_r <= {2'b00, wait_r.setup};
                  end
               end
            end
            default: begin
               state_r <= ppc_pkg::ST_IDLE;
               busy_r <= 1'b0;
            end
         endcase
      end
   end

   // Address and data registers, stepping after each completed access
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         addr_r <= ppc_pkg::RESET_WORD;
         data_r <= ppc_pkg::RESET_WORD;
      end else begin
         if (wr_go && wa == ppc_pkg::OFS_ADDRESS) begin
            if (w_strb_r[0]) addr_r[7:0] <= w_data_r[7:0];
            if (w_strb_r[1]) addr_r[15:8] <= w_data_r[15:8];
         end else if (done && mode_r.step == ppc_pkg::STEP_INC) begin
            {addr_r[15], addr_r[13:0]} <= {addr_r[15], addr_r[13:0]} + 15'h1;
         end else if (done && mode_r.step == ppc_pkg::STEP_DEC) begin
            {addr_r[15], addr_r[13:0]} <= {addr_r[15], addr_r[13:0]} - 15'h1;
         end
         if (start && wr_go && w_strb_r[0]) begin
            data_r[7:0] <= w_data_r[7:0];
            if (mode_r.wide && w_strb_r[1]) data_r[15:8] <= w_data_r[15:8];
         end else if (dir_rd_r && state_r == ppc_pkg::ST_STROBE
            && cnt_r == 4'h0) begin
            if (second_r) data_r[15:8] <= i_data_pins;
            else data_r[7:0] <= i_data_pins;
         end
      end
   end

   // Slave side: pin inputs pass two flip-flops before use
   logic [12:0] sync1_r;
   logic [12:0] sync2_r;
   logic wr_hit;
   logic wr_hit_d_r;
   logic slave_end;
   logic [1:0] slot;
   logic [3:0] sw_read;
   logic [9:0] cap_r;
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync1_r <= 13'h0000;
         sync2_r <= 13'h0000;
         wr_hit_d_r <= 1'b0;
         cap_r <= 10'h000;
      end else begin
         sync1_r <= {i_select_one, i_write_strobe_pin, i_read_strobe_pin,
            i_addr_pins, i_data_pins};
         sync2_r <= sync1_r;
         wr_hit_d_r <= wr_hit;
         // Pins are already released when the end is seen: keep last sample
         if (wr_hit) cap_r <= sync2_r[9:0];
      end
   end
   assign wr_hit = en_r && !master && sync2_r[12] == ctl_r.first_select_polarity
      && sync2_r[11] == ctl_r.write_strobe_polarity;
   assign slave_end = wr_hit_d_r && !wr_hit;
   assign slot = mode_r.mode == ppc_pkg::MODE_ENHANCED ? cap_r[9:8]
      : (mode_r.step == ppc_pkg::STEP_BUFS ? ptr_r : 2'b00);
   assign all_full = (mode_r.mode == ppc_pkg::MODE_ENHANCED
      || mode_r.step == ppc_pkg::STEP_BUFS) ? &full_r : full_r[0];
   always_comb begin
      sw_read = 4'h0;
      if (rd_go && ra >= ppc_pkg::OFS_IN_BUF0 && ra <= ppc_pkg::OFS_IN_BUF3
         && ra[1:0] == 2'b00) begin
         sw_read[2'(ra - ppc_pkg::OFS_IN_BUF0 >> 2)] = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         full_r <= 4'h0;
         ovf_r <= 1'b0;
         ptr_r <= 2'b00;
         for (int k = 0; k < 4; k++) ibuf[k] <= 8'h00;
      end else begin
         // A new write into an empty slot wins over a software read in the same cycle; a full slot overflows
         full_r <= full_r & ~sw_read;
         if (wr_go && wa == ppc_pkg::OFS_IN_STATUS && w_strb_r[0]
            && !w_data_r[ppc_pkg::BIT_OVERFLOW]) begin
            ovf_r <= 1'b0;
         end
         if (slave_end) begin
            if (full_r[slot]) begin
               ovf_r <= 1'b1;
            end else begin
               ibuf[slot] <= cap_r[7:0];
               full_r[slot] <= 1'b1;
            end
            if (mode_r.step == ppc_pkg::STEP_BUFS) ptr_r <= ptr_r + 2'b01;
         end
      end
   end

   // Interrupt pulse and stall level
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_cycle_irq <= 1'b0;
         o_cpu_stall <= 1'b0;
      end else begin
         o_cycle_irq <= (mode_r.irqm == ppc_pkg::IRQ_EACH && (done || slave_end))
            || (mode_r.irqm == ppc_pkg::IRQ_BUF3 && slave_end
            && slot == 2'b11);
         o_cpu_stall <= mode_r.irqm == ppc_pkg::IRQ_STALL
            && (start || (busy_r && !done));
      end
   end

   // Pin levels, computed then registered
   logic act;
   logic strobe_on;
   logic [15:0] pins_nxt;
   always_comb begin
      act = state_r != ppc_pkg::ST_IDLE;
      strobe_on = state_r == ppc_pkg::ST_STROBE;
      pins_nxt = addr_r;
      case (ctl_r.csf)
         ppc_pkg::CSF_TWO_SEL: begin
            pins_nxt[15] = (act && addr_r[15]) ~^ ctl_r.second_select_polarity;
            pins_nxt[14] = (act && addr_r[14]) ~^ ctl_r.first_select_polarity;
         end
         ppc_pkg::CSF_ONE_SEL:
            pins_nxt[15] = (act && addr_r[15]) ~^ ctl_r.second_select_polarity;
         default: ;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_addr_pins <= 16'h0000;
         o_addr_oe <= 16'h0000;
         o_addr_latch_low <= 1'b0;
         o_addr_latch_high <= 1'b0;
         o_byte_enable_pin <= 1'b0;
         o_write_strobe_pin <= 1'b0;
         o_read_strobe_pin <= 1'b0;
         o_enable_strobe_pin <= 1'b0;
         o_strobe_oe <= 1'b0;
         o_data_pins <= 8'h00;
         o_data_oe <= 1'b0;
      end else begin
         o_addr_pins <= pins_nxt;
         o_addr_oe <= (en_r && master) ? pen_r : 16'h0000;
         o_addr_latch_low <= (pen_r[0] && state_r == ppc_pkg::ST_SETUP)
            ~^ ctl_r.addr_latch_polarity;
         o_addr_latch_high <= (pen_r[1] && state_r == ppc_pkg::ST_SETUP)
            ~^ ctl_r.addr_latch_polarity;
         o_byte_enable_pin <= (act && second_r) ~^ ctl_r.byte_lane_polarity;
         o_strobe_oe <= en_r && master;
         if (mode_r.mode == ppc_pkg::MODE_MASTER1) begin
            o_read_strobe_pin <= (act && dir_rd_r) ~^ ctl_r.read_strobe_polarity;
            o_enable_strobe_pin <= strobe_on ~^ ctl_r.write_strobe_polarity;
            o_write_strobe_pin <= !ctl_r.write_strobe_polarity;
         end else begin
            o_read_strobe_pin <= (strobe_on && dir_rd_r) ~^ ctl_r.read_strobe_polarity;
            o_write_strobe_pin <= (strobe_on && !dir_rd_r) ~^ ctl_r.write_strobe_polarity;
            o_enable_strobe_pin <= 1'b0;
         end
         o_data_pins <= second_r ? data_r[15:8] : data_r[7:0];
         o_data_oe <= act && !dir_rd_r && en_r && master;
      end
   end

   logic [4:0] strobe_len_r;
   // Restart per byte: a zero-wait wide access stays in strobe for both bytes
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) strobe_len_r <= 5'h00;
      else if (state_r == ppc_pkg::ST_STROBE && !byte_end)
         strobe_len_r <= strobe_len_r + 5'h01;
      else strobe_len_r <= 5'h00;
   end

   a_busy_follows_fsm: assert property (@(posedge i_ref_clk)
      disable iff (!i_reset_n)
      busy_r == (state_r != ppc_pkg::ST_IDLE))
      else $error("busy flag disagrees with sequencer");
   a_strobe_length: assert property (@(posedge i_ref_clk)
      disable iff (!i_reset_n)
      (state_r == ppc_pkg::ST_STROBE && cnt_r == 4'h0)
      |-> strobe_len_r == {1'b0, wait_r.strobe})
      else $error("strobe length wrong");
   a_zero_wait_skip: assert property (@(posedge i_ref_clk)
      disable iff (!i_reset_n)
      (start && wait_r.strobe == 4'h0) |=> state_r == ppc_pkg::ST_STROBE
      ##1 state_r != ppc_pkg::ST_HOLD)
      else $error("setup or hold used with zero strobe wait");
   a_setup_count: assert property (@(posedge i_ref_clk)
      disable iff (!i_reset_n)
      (start && wait_r.strobe != 4'h0 && wait_r.setup == 2'b01)
      |=> state_r == ppc_pkg::ST_SETUP [*2] ##1 state_r == ppc_pkg::ST_STROBE)
      else $error("setup phase length wrong");
   a_hold_entry: assert property (@(posedge i_ref_clk)
      disable iff (!i_reset_n)
      (state_r == ppc_pkg::ST_STROBE && cnt_r == 4'h0 && wait_r.strobe != 4'h0)
      |=> state_r == ppc_pkg::ST_HOLD && cnt_r == {2'b00, $past(wait_r.hold)})
      else $error("hold phase not entered");
   a_disabled_quiet: assert property (@(posedge i_ref_clk)
      disable iff (!i_reset_n)
      !en_r |=> o_addr_oe == 16'h0000 && !o_data_oe && !o_strobe_oe)
      else $error("disabled port drives pins");
   a_overflow_set: assert property (@(posedge i_ref_clk)
      disable iff (!i_reset_n)
      (slave_end && full_r[slot]) |=> ovf_r)
      else $error("overflow not flagged");
   a_slot_cleared: assert property (@(posedge i_ref_clk)
      disable iff (!i_reset_n)
      (sw_read != 4'h0 && !slave_end) |=> (full_r & $past(sw_read)) == 4'h0)
      else $error("slot full not cleared by read");
   a_step_increment: assert property (@(posedge i_ref_clk)
      disable iff (!i_reset_n)
      (done && mode_r.step == ppc_pkg::STEP_INC && !wr_go)
      |=> addr_r[13:0] == $past(addr_r[13:0]) + 14'h1
      || (addr_r[13:0] == 14'h0000 && addr_r[15] != $past(addr_r[15])))
      else $error("address did not step");
   a_wide_two_bytes: assert property (@(posedge i_ref_clk)
      disable iff (!i_reset_n)
      (byte_end && mode_r.wide && !second_r && en_r) |=> second_r && busy_r)
      else $error("second byte not performed");
endmodule : ppc_port_top

// file: verif/ppc_host_model.sv
// External host and memory pins facing the parallel port
module ppc_host_model (
   input wire logic i_ref_clk,
   input wire logic i_write_strobe_pin,
   input wire logic [7:0] i_data_pins,
   output logic o_select_one,
   output logic o_write_strobe_pin,
   output logic o_read_strobe_pin,
   output logic [1:0] o_addr_pins,
   output logic [7:0] o_data_pins,
   output logic [7:0] o_last
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_select_one = 1'h0;
      o_write_strobe_pin = 1'h0;
      o_read_strobe_pin = 1'h0;
      o_addr_pins = 2'h0;
      o_data_pins = 8'h00;
      o_last = 8'h00;
   end
   // Memory side keeps what a master write strobes out
   always @(posedge i_ref_clk) begin
      if (i_write_strobe_pin === 1'h1) o_last <= i_data_pins;
   end
   // Active-high strobes; released data inverted so it never looks held
   task put(input logic [7:0] d, input logic [1:0] a);
      @(posedge i_ref_clk);
      o_select_one <= 1'h1;
      o_write_strobe_pin <= 1'h1;
      o_addr_pins <= a;
      o_data_pins <= d;
      repeat (3) @(posedge i_ref_clk);
      o_select_one <= 1'h0;
      o_write_strobe_pin <= 1'h0;
      o_data_pins <= ~d;
   endtask : put
endmodule : ppc_host_model

// file: verif/test_parallel_port_config_status.sv
// Self-checking bench for the parallel port block
`define CHK(n,e,s) begin n_checks++; if ((s) !== (e)) begin fails++; \
$display("BAD %s exp %h got %h", n, e, s); end end
module test_parallel_port_config_status;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, awv, wv, bry, arv, rry;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat;
   logic [1:0] resp;
   wire logic awr, wr, bv, arr, rv, sel1, wrin, rdin, wr_pin, be_pin, irq;
   wire logic [1:0] br, rr, apin;
   wire logic [7:0] din, dout, mlast;
   wire logic [31:0] rd_d;
   int fails, n_checks, nwr, nbe, nirq;
   ppc_port_top DUT (.i_ref_clk(clk), .i_reset_n(rst_n),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
      .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .i_s_axi_wdata(wd),
      .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry),
      .o_s_axi_bresp(br), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
      .o_s_axi_rdata(rd_d), .o_s_axi_rresp(rr), .i_select_one(sel1),
      .i_write_strobe_pin(wrin), .i_read_strobe_pin(rdin),
      .i_addr_pins(apin), .i_data_pins(din), .o_addr_pins(), .o_addr_oe(),
      .o_addr_latch_low(), .o_addr_latch_high(),
      .o_byte_enable_pin(be_pin), .o_write_strobe_pin(wr_pin),
      .o_read_strobe_pin(), .o_enable_strobe_pin(), .o_strobe_oe(),
      .o_data_pins(dout), .o_data_oe(), .o_cycle_irq(irq), .o_cpu_stall());
   ppc_host_model host (.i_ref_clk(clk), .i_write_strobe_pin(wr_pin),
      .i_data_pins(dout), .o_select_one(sel1), .o_write_strobe_pin(wrin),
      .o_read_strobe_pin(rdin), .o_addr_pins(apin), .o_data_pins(din),
      .o_last(mlast));
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (wr_pin === 1'h1) nwr <= nwr + 1;
      if (be_pin === 1'h1) nbe <= nbe + 1;
      if (irq === 1'h1) nirq <= nirq + 1;
   end
   task summarize;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      int k;
      @(posedge clk);
      {awv, wv, bry} <= 3'h7;
      awa <= a;
      wd <= {16'h0000, d};
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (awr === 1'h1) awv <= 1'h0;
         if (wr === 1'h1) wv <= 1'h0;
         if (bv === 1'h1) break;
      end
      bry <= 1'h0;
      resp = br;
      if (k == 40) begin fails++; summarize(); end
   endtask : wr_reg
   task rd_reg(input logic [7:0] a);
      int k;
      @(posedge clk);
      {arv, rry} <= 2'h3;
      ara <= a;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (arr === 1'h1) arv <= 1'h0;
         if (rv === 1'h1) break;
      end
      rry <= 1'h0;
      rdat = rd_d;
      resp = rr;
      if (k == 40) begin fails++; summarize(); end
   endtask : rd_reg
   task t_regs;
      logic [7:0] ofs [6];
      int i;
      ofs = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
      for (i = 0; i < 6; i++) begin
         rd_reg(ofs[i]);
         `CHK("reset", 16'h0000, rdat[15:0])
         if (i != 1 && i != 5) begin
            wr_reg(ofs[i], 16'h00A5);
            rd_reg(ofs[i]);
            `CHK("rw", 16'h00A5, rdat[15:0])
            wr_reg(ofs[i], 16'h0000);
         end
      end
      wr_reg(8'h08, 16'h00FF);
      rd_reg(8'h08);
      `CHK("busy ro", 16'h007F, rdat[15:0])
      wr_reg(8'h08, 16'h0000);
      wr_reg(8'h3C, 16'h0001);
      `CHK("wr err", 2'h2, resp)
      rd_reg(8'h3C);
      `CHK("rd err", 2'h2, resp)
      $display("t_regs done");
   endtask : t_regs
   // Strobe length, byte order and busy span of one master write
   task t_master(input logic [7:0] cfg, input logic w, input logic [15:0] d,
         input int cyc, input logic [7:0] last, input logic bsy);
      logic [15:0] a0;
      wr_reg(8'h04, 16'h000E);
      wr_reg(8'h08, {11'h000, 2'b01, w, 2'h2});
      wr_reg(8'h0C, {8'h00, cfg});
      wr_reg(8'h00, 16'h0080);
      rd_reg(8'h1C);
      a0 = rdat[15:0];
      nwr = 0;
      nbe = 0;
      wr_reg(8'h20, d);
      rd_reg(8'h08);
      `CHK("busy", bsy, rdat[7])
      repeat (40) @(posedge clk);
      `CHK("strobes", cyc, nwr)
      `CHK("last", last, mlast)
      `CHK("be", w, nbe > 0)
      rd_reg(8'h08);
      `CHK("idle", 1'h0, rdat[7])
      rd_reg(8'h1C);
      `CHK("step", a0 + 16'h1, rdat[15:0])
      wr_reg(8'h00, 16'h0000);
      $display("t_master done");
   endtask : t_master
   task t_slave;
      wr_reg(8'h04, 16'h000E);
      wr_reg(8'h08, 16'h0020);
      wr_reg(8'h00, 16'h0080);
      host.put(8'h3C, 2'h0);
      repeat (6) @(posedge clk);
      rd_reg(8'h18);
      `CHK("full", 16'h0081, rdat[15:0])
      `CHK("irq", 1, nirq)
      host.put(8'h77, 2'h0);
      repeat (6) @(posedge clk);
      rd_reg(8'h18);
      `CHK("ovf", 16'h00C1, rdat[15:0])
      rd_reg(8'h24);
      `CHK("data", 16'h003C, rdat[15:0])
      rd_reg(8'h18);
      `CHK("read clr", 16'h0040, rdat[15:0])
      wr_reg(8'h18, 16'h0000);
      rd_reg(8'h18);
      `CHK("sw clr", 16'h0000, rdat[15:0])
      $display("t_slave done");
   endtask : t_slave
   initial begin
      {rst_n, awv, wv, bry, arv, rry} = 6'h00;
      {awa, ara, wd} = 48'h0000_0000_0000;
      {fails, n_checks, nwr, nbe, nirq} = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      t_regs();
      t_master(8'h49, 1'h0, 16'h005A, 3, 8'h5A, 1'h1);
      t_master(8'hC3, 1'h0, 16'h00C3, 1, 8'hC3, 1'h0);
      t_master(8'h49, 1'h1, 16'h1234, 6, 8'h12, 1'h1);
      t_slave();
      summarize();
   end
endmodule : test_parallel_port_config_status
